// File: core/eidc_top.sv
// Purpose: event input detection and time stamp control register
// Assumes: register port and pins are synchronous to MCLK_IN
// Notes: stamp registers and event flag live outside this block
`timescale 1ns/1ns
module eidc_top
#(
    parameter int unsigned CYC_256HZ = eidc_pkg::EIDC_CYC_256HZ,
    parameter int unsigned CYC_64HZ = eidc_pkg::EIDC_CYC_64HZ,
    parameter int unsigned CYC_8HZ = eidc_pkg::EIDC_CYC_8HZ
)
(
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    // register access
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic WRITE_PROTECT_IN,
    output logic [7:0] REG_RDATA_OUT,
    // event sources and stamp status
    input wire logic EVENT_INPUT_PIN_IN,
    input wire logic BACKUP_SUPPLY_STATE_IN,
    input wire logic STAMP_ENABLE_IN,
    input wire logic EVENT_FLAG_IN,
    // event and stamp control
    output logic EVENT_DETECT_OUT,
    output logic STAMP_CAPTURE_OUT,
    output logic STAMP_CLEAR_OUT
);
    import eidc_pkg::*;

    typedef struct packed
    {
        logic [7:0] ctrl;
        logic [7:0] rdata;
        logic pin;
        logic act_prev;
        logic samp;
        logic filt;
        logic bkp_prev;
        logic evt;
        logic cap;
        logic clr;
    } eidc_top_st_t;

    eidc_top_st_t st_ff;
    eidc_top_st_t nxt_st;
    // act_prev high: a pin already at its level over reset is no edge
    localparam eidc_top_st_t ST_RST = '{ctrl: EIDC_CTRL_RST, act_prev: 1'b1, default: '0};
    logic tick;
    logic act;
    logic pin_evt;
    logic bkp_evt;
    logic src_evt;
    logic wr_hit;
    logic [31:0] period;
    eidc_flt_t flt;

    // ----------------------------------------------------------------
    // filter period selection
    // ----------------------------------------------------------------
    assign flt = eidc_flt_t'(st_ff.ctrl[EIDC_BIT_FLT_HI:EIDC_BIT_FLT_LO]);

    always_comb
    begin
        unique case (flt)
            EIDC_FLT_256HZ: period = CYC_256HZ;
            EIDC_FLT_64HZ: period = CYC_64HZ;
            EIDC_FLT_8HZ: period = CYC_8HZ;
            EIDC_FLT_OFF: period = EIDC_CNT_ONE;
        endcase
    end

    eidc_tick u_tick
    (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .run_in(flt != EIDC_FLT_OFF),
        .period_in(period),
        .tick_out(tick)
    );

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    // active level seen on the registered pin
    assign act = st_ff.ctrl[EIDC_BIT_LVL] ? st_ff.pin : ~st_ff.pin;
    assign pin_evt = (flt == EIDC_FLT_OFF) ? (act & ~st_ff.act_prev)
                                            : (tick & act & st_ff.samp & ~st_ff.filt);
    assign bkp_evt = BACKUP_SUPPLY_STATE_IN & ~st_ff.bkp_prev;
    assign src_evt = st_ff.ctrl[EIDC_BIT_SRC] ? bkp_evt : pin_evt;
    assign wr_hit = REG_WR_IN && (REG_ADDR_IN == EIDC_REG_EVT_CTRL);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pin = EVENT_INPUT_PIN_IN;
        nxt_st.act_prev = act;
        nxt_st.bkp_prev = BACKUP_SUPPLY_STATE_IN;
        nxt_st.clr = 1'b0;
        if (tick)
        begin
            nxt_st.samp = act;
            // stable level only after two equal samples
            if (act == st_ff.samp)
            begin
                nxt_st.filt = act;
            end
        end
        nxt_st.evt = pin_evt;
        nxt_st.cap = src_evt && STAMP_ENABLE_IN
                     && (st_ff.ctrl[EIDC_BIT_OVW] || !EVENT_FLAG_IN);
        // self clearing stamp clear
        if (st_ff.ctrl[EIDC_BIT_CLR])
        begin
            nxt_st.ctrl[EIDC_BIT_CLR] = 1'b0;
            nxt_st.clr = 1'b1;
        end
        if (wr_hit && !WRITE_PROTECT_IN)
        begin
            nxt_st.ctrl = REG_WDATA_IN & EIDC_CTRL_WMASK;
        end
        if (REG_RD_IN)
        begin
            nxt_st.rdata = (REG_ADDR_IN == EIDC_REG_EVT_CTRL) ? st_ff.ctrl
                                                              : EIDC_RDATA_IDLE;
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            st_ff <= ST_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign REG_RDATA_OUT = st_ff.rdata;
    assign EVENT_DETECT_OUT = st_ff.evt;
    assign STAMP_CAPTURE_OUT = st_ff.cap;
    assign STAMP_CLEAR_OUT = st_ff.clr;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_bit7_zero;
        @(posedge MCLK_IN) disable iff (RST_IN)
        $past(REG_RD_IN) |-> REG_RDATA_OUT[7] == 1'b0;
    endproperty
    a_bit7_zero: assert property (p_bit7_zero)
        else $error("bit 7 read as one");

    property p_protect;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (wr_hit && WRITE_PROTECT_IN && !st_ff.ctrl[EIDC_BIT_CLR]) |=> $stable(st_ff.ctrl);
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected write changed control");

    property p_clear_pulse;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (wr_hit && !WRITE_PROTECT_IN && REG_WDATA_IN[EIDC_BIT_CLR]) |=> ##1 STAMP_CLEAR_OUT;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse)
        else $error("stamp clear pulse missing");

    property p_clear_self;
        @(posedge MCLK_IN) disable iff (RST_IN)
        STAMP_CLEAR_OUT && !$past(wr_hit) |-> !st_ff.ctrl[EIDC_BIT_CLR];
    endproperty
    a_clear_self: assert property (p_clear_self)
        else $error("stamp clear bit stuck");

    property p_edge_detect;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (flt == EIDC_FLT_OFF && act && !st_ff.act_prev) |=> EVENT_DETECT_OUT;
    endproperty
    a_edge_detect: assert property (p_edge_detect)
        else $error("edge event missed");

    property p_filter_tick;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (EVENT_DETECT_OUT && $past(flt) != EIDC_FLT_OFF) |-> $past(tick) && $past(st_ff.samp);
    endproperty
    a_filter_tick: assert property (p_filter_tick)
        else $error("filtered event without stable sample");

    property p_first_only;
        @(posedge MCLK_IN) disable iff (RST_IN)
        STAMP_CAPTURE_OUT |-> $past(st_ff.ctrl[EIDC_BIT_OVW]) || !$past(EVENT_FLAG_IN);
    endproperty
    a_first_only: assert property (p_first_only)
        else $error("capture while flag set in first event mode");

    property p_pin_stamp;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (!st_ff.ctrl[EIDC_BIT_SRC] && pin_evt && STAMP_ENABLE_IN && !EVENT_FLAG_IN)
            |=> STAMP_CAPTURE_OUT;
    endproperty
    a_pin_stamp: assert property (p_pin_stamp)
        else $error("pin event not stamped");

    property p_backup_stamp;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (st_ff.ctrl[EIDC_BIT_SRC] && bkp_evt && STAMP_ENABLE_IN && st_ff.ctrl[EIDC_BIT_OVW])
            |=> STAMP_CAPTURE_OUT;
    endproperty
    a_backup_stamp: assert property (p_backup_stamp)
        else $error("backup switchover not stamped");

    property p_reset_value;
        @(posedge MCLK_IN)
        (!RST_IN && $past(RST_IN)) |-> st_ff.ctrl == EIDC_CTRL_RST && !STAMP_CAPTURE_OUT
            && !EVENT_DETECT_OUT && !STAMP_CLEAR_OUT;
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("control not zero after reset");
endmodule

// File: core/eidc_pkg.sv
// Purpose: constants for the event input detect and stamp control block
// Assumes: one clock at 250 MHz, synchronous active-high reset
// Notes: the event control register sits at offset 0x13
package eidc_pkg;
    localparam logic [7:0] EIDC_REG_EVT_CTRL = 8'h13;
    localparam logic [7:0] EIDC_CTRL_RST = 8'h00;
    localparam logic [7:0] EIDC_CTRL_WMASK = 8'h77;
    localparam logic [7:0] EIDC_RDATA_IDLE = 8'h00;
    localparam int EIDC_BIT_LVL = 6;
    localparam int EIDC_BIT_FLT_HI = 5;
    localparam int EIDC_BIT_FLT_LO = 4;
    localparam int EIDC_BIT_CLR = 2;
    localparam int EIDC_BIT_OVW = 1;
    localparam int EIDC_BIT_SRC = 0;

    typedef enum logic [1:0]
    {
        EIDC_FLT_OFF = 2'b00,
        EIDC_FLT_256HZ = 2'b01,
        EIDC_FLT_64HZ = 2'b10,
        EIDC_FLT_8HZ = 2'b11
    } eidc_flt_t;

    localparam int unsigned EIDC_CLK_NS = 4;
    localparam int unsigned EIDC_T256_NS = 3_900_000;
    localparam int unsigned EIDC_T64_NS = 15_600_000;
    localparam int unsigned EIDC_T8_NS = 125_000_000;
    localparam int unsigned EIDC_CYC_256HZ = EIDC_T256_NS / EIDC_CLK_NS;
    localparam int unsigned EIDC_CYC_64HZ = EIDC_T64_NS / EIDC_CLK_NS;
    localparam int unsigned EIDC_CYC_8HZ = EIDC_T8_NS / EIDC_CLK_NS;
    localparam logic [31:0] EIDC_CNT_ZERO = 32'h0000_0000;
    localparam logic [31:0] EIDC_CNT_ONE = 32'h0000_0001;
endpackage

// File: core/eidc_tick.sv
// Purpose: sample tick generator for the glitch filter
// Assumes: period_in stays put while run_in is high
// Notes: counter restarts whenever run_in drops
`timescale 1ns/1ns
module eidc_tick
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control
    input wire logic run_in,
    input wire logic [31:0] period_in,
    // tick
    output logic tick_out
);
    import eidc_pkg::*;

    typedef struct packed
    {
        logic [31:0] cnt;
        logic tick;
    } eidc_tick_st_t;

    eidc_tick_st_t st_ff;
    eidc_tick_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!run_in)
        begin
            nxt_st.cnt = EIDC_CNT_ZERO;
        end
        else if (st_ff.cnt >= period_in - EIDC_CNT_ONE)
        begin
            nxt_st.cnt = EIDC_CNT_ZERO;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + EIDC_CNT_ONE;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign tick_out = st_ff.tick;

    property p_tick_period;
        @(posedge clk_in) disable iff (rst_in)
        st_ff.tick |-> st_ff.cnt == EIDC_CNT_ZERO;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("tick without counter restart");
endmodule

// File: tb/eidc_src.sv
// Purpose: model of the external event source on the input pin and backup state
// Assumes: changes come just after a rising edge of the bench clock
// Notes: every pulse is followed by a quiet gap so outcomes never overlap
`timescale 1ns/1ns
module eidc_src
(
    // clock
    input wire logic clk_in,
    // event lines
    output logic pin_out,
    output logic bkp_out
);
    localparam int DLY = 1;
    localparam int GAP = 24;

    initial
    begin
        pin_out = 1'b1;
        bkp_out = 1'b0;
    end

    task automatic pin_set(input logic lvl);
        @(posedge clk_in);
        #DLY;
        pin_out = lvl;
        repeat (GAP) @(posedge clk_in);
    endtask

    task automatic pin_pulse(input logic lvl, input int n);
        @(posedge clk_in);
        #DLY;
        pin_out = lvl;
        repeat (n) @(posedge clk_in);
        #DLY;
        pin_out = ~lvl;
        repeat (GAP) @(posedge clk_in);
    endtask

    task automatic bkp_pulse(input int n);
        @(posedge clk_in);
        #DLY;
        bkp_out = 1'b1;
        repeat (n) @(posedge clk_in);
        #DLY;
        bkp_out = 1'b0;
        repeat (GAP) @(posedge clk_in);
    endtask
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for the event detect and stamp control block
// Assumes: eidc_src drives the event pin and backup state
// Notes: expected reads and pulses are queued, a monitor pops and compares them
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import eidc_pkg::*;
    localparam int DLY = 1;
    logic clk = 0, rst = 1, wr = 0, rd = 0, wp = 0, ten = 1, flg = 0, rd_pend = 0, p, o;
    logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, shadow, d, a, re;
    logic det, cap, clr, pin, bkp;
    logic [2:0] pe;
    logic [7:0] rd_q[$];
    logic [2:0] ev_q[$];
    int err_count = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;

    eidc_src u_src (.clk_in(clk), .pin_out(pin), .bkp_out(bkp));

    eidc_top #(.CYC_256HZ(4), .CYC_64HZ(8), .CYC_8HZ(16)) u_dut
    (
        .MCLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_WDATA_IN(wdat), .WRITE_PROTECT_IN(wp), .REG_RDATA_OUT(rdat),
        .EVENT_INPUT_PIN_IN(pin), .BACKUP_SUPPLY_STATE_IN(bkp), .STAMP_ENABLE_IN(ten),
        .EVENT_FLAG_IN(flg), .EVENT_DETECT_OUT(det), .STAMP_CAPTURE_OUT(cap),
        .STAMP_CLEAR_OUT(clr)
    );

    // ----------------------------------------
    // monitor: pops the oldest note per result
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (rd_pend)
        begin
            re = rd_q.pop_front();
            `CHK(rdat, re)
        end
        rd_pend = rd;
        if (!rst && {det, cap, clr} !== 3'b000)
        begin
            pe = (ev_q.size() > 0) ? ev_q.pop_front() : 3'b000;
            `CHK({det, cap, clr}, pe)
        end
    end

    task automatic reg_wr(input logic [7:0] ta, input logic [7:0] td, input logic tp);
        @(posedge clk);
        #DLY;
        addr = ta;
        wdat = td;
        wp = tp;
        wr = 1'b1;
        @(posedge clk);
        #DLY;
        wr = 1'b0;
        wp = 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] ta, input logic [7:0] te);
        rd_q.push_back(te);
        @(posedge clk);
        #DLY;
        addr = ta;
        rd = 1'b1;
        @(posedge clk);
        #DLY;
        rd = 1'b0;
    endtask

    task automatic ev(input logic [2:0] te, input logic lvl, input int n);
        if (te != 3'b000)
            ev_q.push_back(te);
        if (n == 0)
            u_src.pin_set(lvl);
        else
            u_src.pin_pulse(lvl, n);
        `CHK(ev_q.size(), 0)
        #DLY;
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h165b));
        repeat (3) @(posedge clk);
        #DLY;
        rst = 0;
        reg_rd(EIDC_REG_EVT_CTRL, EIDC_CTRL_RST);
        reg_rd(8'h12, EIDC_RDATA_IDLE);
        shadow = EIDC_CTRL_RST;
        // random writes, some protected or unmapped; polarity kept low
        for (int i = 0; i < 8; i++)
        begin
            d = 8'($urandom) & 8'hbf;
            p = 1'($urandom);
            a = (i == 5) ? 8'h14 : EIDC_REG_EVT_CTRL;
            if (!p && a == EIDC_REG_EVT_CTRL)
            begin
                shadow = d & 8'h73;
                if (d[EIDC_BIT_CLR])
                    ev_q.push_back(3'b001);
            end
            reg_wr(a, d, p);
            repeat (3) @(posedge clk);
            reg_rd(EIDC_REG_EVT_CTRL, shadow);
        end
        `CHK(ev_q.size(), 0)
        // plain edge mode, low polarity
        reg_wr(EIDC_REG_EVT_CTRL, 8'h00, 1'b0);
        ev(3'b110, 1'b0, $urandom_range(5, 2));
        ten = 0;
        ev(3'b100, 1'b0, 2);
        ten = 1;
        flg = 1;
        ev(3'b100, 1'b0, 3);
        reg_wr(EIDC_REG_EVT_CTRL, 8'h02, 1'b0);
        ev(3'b110, 1'b0, 3);
        flg = 0;
        // random stamp enable, flag and overwrite mode
        for (int i = 0; i < 4; i++)
        begin
            o = 1'($urandom);
            ten = 1'($urandom);
            flg = 1'($urandom);
            reg_wr(EIDC_REG_EVT_CTRL, {6'h00, o, 1'b0}, 1'b0);
            ev({1'b1, ten && (o || !flg), 1'b0}, 1'b0, 2);
        end
        ten = 1;
        flg = 0;
        reg_wr(EIDC_REG_EVT_CTRL, 8'h00, 1'b0);
        ev(3'b110, 1'b0, 0);
        // high polarity, then the three sampled filters
        reg_wr(EIDC_REG_EVT_CTRL, 8'h40, 1'b0);
        ev(3'b110, 1'b1, $urandom_range(5, 2));
        reg_wr(EIDC_REG_EVT_CTRL, 8'h50, 1'b0);
        ev(3'b000, 1'b1, 1);
        ev(3'b110, 1'b1, 16);
        reg_wr(EIDC_REG_EVT_CTRL, 8'h60, 1'b0);
        ev(3'b000, 1'b1, 1);
        ev(3'b110, 1'b1, 40);
        reg_wr(EIDC_REG_EVT_CTRL, 8'h70, 1'b0);
        ev(3'b110, 1'b1, 60);
        // backup switchover as stamp source
        reg_wr(EIDC_REG_EVT_CTRL, 8'h41, 1'b0);
        ev(3'b100, 1'b1, 3);
        ev_q.push_back(3'b010);
        u_src.bkp_pulse(4);
        `CHK(ev_q.size(), 0)
        // backup source in overwrite mode with the flag set
        reg_wr(EIDC_REG_EVT_CTRL, 8'h43, 1'b0);
        flg = 1;
        ev_q.push_back(3'b010);
        u_src.bkp_pulse(4);
        `CHK(ev_q.size(), 0)
        tally_and_finish();
    end
endmodule
